// ===== design/tco_top.sv
// Timer compare-output control with 16-bit register access path
`timescale 1ns/1ps
module tco_top (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // I/O bus
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output logic      [7:0] io_rdata,
    // 16-bit access strobes from the timer register decode
    input  wire logic       wide_lo_wr,
    input  wire logic       wide_hi_wr,
    input  wire logic       wide_lo_rd,
    input  wire logic [7:0] wide_hi_src,
    output logic      [7:0] wide_temp,
    output logic      [15:0] wide_wdata,
    output logic       wide_load,
    // Waveform select upper bits from the second control register
    input  wire logic [1:0] waveform_sel_high,
    // Timer events
    input  wire logic       match_a,
    input  wire logic       match_b,
    input  wire logic       match_a_is_top,
    input  wire logic       match_b_is_top,
    input  wire logic       at_top,
    input  wire logic       count_down,
    input  wire logic       force_a,
    input  wire logic       force_b,
    // Outputs
    output logic       wave_out_a,
    output logic       wave_out_b,
    output logic       pin_override_a,
    output logic       pin_override_b
);
    import tco_pkg::*;

    logic [7:0]     ctrl_reg;
    logic [7:0]     ctrl_next;
    logic [7:0]     temp_reg;
    logic [7:0]     temp_next;
    logic [15:0]    wdata_reg;
    logic [15:0]    wdata_next;
    logic           load_reg;
    logic           load_next;
    logic [7:0]     rdata_reg;
    logic [7:0]     rdata_next;
    logic [3:0]     waveform_sel;
    tco_wclass_type wclass;

    // ----------------------------------------
    // Control register and read path
    // ----------------------------------------
    always_comb begin
        ctrl_next  = ctrl_reg;
        rdata_next = 8'h00;
        if (io_wr && io_addr == TCO_CTRL_A_ADDR) begin
            ctrl_next = io_wdata & TCO_CTRL_A_WMASK;
        end
        if (io_rd && io_addr == TCO_CTRL_A_ADDR) begin
            rdata_next = ctrl_reg;
        end
    end

    // ----------------------------------------
    // Shared upper-byte temporary
    // ----------------------------------------
    // Low-byte access is the trigger; high byte only parks in temp
    always_comb begin
        temp_next  = temp_reg;
        wdata_next = wdata_reg;
        load_next  = 1'b0;
        if (wide_hi_wr) begin
            temp_next = io_wdata;
        end
        // low write commits temp plus low byte
        if (wide_lo_wr) begin
            wdata_next = {temp_reg, io_wdata};
            load_next  = 1'b1;
        end
        // low read latches source upper byte
        if (wide_lo_rd) begin
            temp_next = wide_hi_src;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg  <= TCO_CTRL_A_RESET;
            temp_reg  <= TCO_BYTE_RESET;
            wdata_reg <= 16'h0000;
            load_reg  <= 1'b0;
            rdata_reg <= TCO_BYTE_RESET;
        end else begin
            ctrl_reg  <= ctrl_next;
            temp_reg  <= temp_next;
            wdata_reg <= wdata_next;
            load_reg  <= load_next;
            rdata_reg <= rdata_next;
        end
    end

    assign io_rdata   = rdata_reg;
    assign wide_temp  = temp_reg;
    assign wide_wdata = wdata_reg;
    assign wide_load  = load_reg;

    // ----------------------------------------
    // Mode decode and channels
    // ----------------------------------------
    // four select bits to waveform class
    assign waveform_sel = {waveform_sel_high, ctrl_reg[1:0]};
    assign wclass       = tco_decode(waveform_sel);

    // Channel A may toggle in PWM; channel B's code 01 is reserved
    tco_chan u_chan_a (
        .mclk                 (mclk),
        .arst_n               (arst_n),
        .chan_out_mode        (ctrl_reg[TCO_MODE_A_POS +: 2]),
        .wclass               (wclass),
        .waveform_sel_top_bit (waveform_sel[3]),
        .toggle_allowed       (1'b1),
        .match                (match_a),
        .at_top               (at_top),
        .match_is_top         (match_a_is_top),
        .count_down           (count_down),
        .force_match          (force_a),
        .wave_out             (wave_out_a),
        .pin_override         (pin_override_a)
    );

    tco_chan u_chan_b (
        .mclk                 (mclk),
        .arst_n               (arst_n),
        .chan_out_mode        (ctrl_reg[TCO_MODE_B_POS +: 2]),
        .wclass               (wclass),
        .waveform_sel_top_bit (waveform_sel[3]),
        .toggle_allowed       (1'b0),
        .match                (match_b),
        .at_top               (at_top),
        .match_is_top         (match_b_is_top),
        .count_down           (count_down),
        .force_match          (force_b),
        .wave_out             (wave_out_b),
        .pin_override         (pin_override_b)
    );

    // low write carries temp as upper byte
    wide_commit_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (wide_lo_wr && !wide_hi_wr && !wide_lo_rd) |=> wide_load && wide_wdata == {$past(temp_reg), $past(io_wdata)})
        else $error("16-bit commit wrong");
    rsvd_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
        ctrl_reg[3:2] == 2'b00)
        else $error("reserved bits set");
    override_a_a: assert property (@(posedge mclk) disable iff (!arst_n)
        pin_override_a == (ctrl_reg[7:6] != 2'b00))
        else $error("channel A override wrong");
    override_b_a: assert property (@(posedge mclk) disable iff (!arst_n)
        pin_override_b == (ctrl_reg[5:4] != 2'b00))
        else $error("channel B override wrong");
    decode_ctc_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (waveform_sel == 4'h4 || waveform_sel == 4'hc) |-> wclass == TCO_WC_CTC)
        else $error("mode decode wrong");

    // ----------------------------------------
    // Register path and decode checks
    // ----------------------------------------
    // High byte parked, one quiet cycle, then the low byte
    sequence wide_hi_s;
        wide_hi_wr && !wide_lo_rd;
    endsequence
    sequence wide_quiet_s;
        !wide_hi_wr && !wide_lo_rd;
    endsequence
    sequence wide_lo_s;
        wide_lo_wr && !wide_hi_wr && !wide_lo_rd;
    endsequence

    // parked high byte lands above the low byte
    wide_pair_a: assert property (@(posedge mclk) disable iff (!arst_n)
        wide_hi_s ##1 wide_quiet_s ##1 wide_lo_s |=> wide_wdata == {$past(io_wdata, 3), $past(io_wdata)})
        else $error("16-bit pair commit wrong");
    // low read parks the source high byte
    lo_rd_latch_a: assert property (@(posedge mclk) disable iff (!arst_n)
        wide_lo_rd |=> wide_temp == $past(wide_hi_src))
        else $error("low read latch wrong");
    // commit pulse only after a low write
    load_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !wide_lo_wr |=> !wide_load)
        else $error("stray commit pulse");
    // committed word holds between low writes
    wdata_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !wide_lo_wr |=> $stable(wide_wdata))
        else $error("committed word changed");
    // control write keeps only writable bits
    ctrl_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (io_wr && io_addr == TCO_CTRL_A_ADDR) |=> ctrl_reg == ($past(io_wdata) & TCO_CTRL_A_WMASK))
        else $error("control write wrong");
    // control register holds without a write
    ctrl_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !(io_wr && io_addr == TCO_CTRL_A_ADDR) |=> $stable(ctrl_reg))
        else $error("control register changed");
    // read returns the masked control value
    rd_ctrl_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (io_rd && io_addr == TCO_CTRL_A_ADDR) |=> io_rdata == $past(ctrl_reg))
        else $error("control read wrong");
    // any other cycle reads back zero
    rd_other_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !(io_rd && io_addr == TCO_CTRL_A_ADDR) |=> io_rdata == 8'h00)
        else $error("idle read data not zero");
    decode_fast_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (waveform_sel == 4'h5 || waveform_sel == 4'h6 || waveform_sel == 4'h7
         || waveform_sel == 4'he || waveform_sel == 4'hf) |-> wclass == TCO_WC_FAST)
        else $error("fast decode wrong");
    decode_phase_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (waveform_sel == 4'h1 || waveform_sel == 4'h2 || waveform_sel == 4'h3
         || waveform_sel == 4'ha || waveform_sel == 4'hb) |-> wclass == TCO_WC_PHASE)
        else $error("phase decode wrong");
    decode_pfc_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (waveform_sel[3:1] == 3'b100) |-> wclass == TCO_WC_PFC)
        else $error("freq-correct decode wrong");
    decode_rsvd_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (waveform_sel == 4'hd) |-> wclass == TCO_WC_RSVD)
        else $error("reserved decode wrong");
endmodule

// ===== design/tco_pkg.sv
// Package of constants and types for the timer compare-output control block
//
// Behaviour
// - Nonzero channel A mode field (bits 7:6) hands pin to wave_out_a.
// - Nonzero channel B mode field (bits 5:4) hands pin to wave_out_b.
// - Each mode field is interpreted per waveform class: non-PWM, fast, phase-correct.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at TOP; 11 the reverse.
// - PWM mode 01: output holds (pin still taken) when top select bit 0; else A toggles, B reserved.
// - Fast PWM with compare equal TOP and upper bit set: ignore match.
// - Phase-correct: 10 clears on up-match, sets on down-match; 11 reverse.
// - Lower-byte write loads temp and data; lower-byte read latches upper byte.
// - Four waveform select bits decode to normal, match-clear, fast, phase modes.
package tco_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] TCO_CTRL_A_ADDR  = 8'h2f;
    localparam logic [7:0] TCO_CTRL_A_RESET = 8'h00;
    localparam logic [7:0] TCO_CTRL_A_WMASK = 8'hf3;
    localparam int         TCO_MODE_A_POS   = 6;
    localparam int         TCO_MODE_B_POS   = 4;
    localparam logic [7:0] TCO_BYTE_RESET   = 8'h00;

    // ----------------------------------------
    // Output mode codes and waveform classes
    // ----------------------------------------
    localparam logic [1:0] TCO_OM_OFF    = 2'h0;
    localparam logic [1:0] TCO_OM_TOGGLE = 2'h1;
    localparam logic [1:0] TCO_OM_CLEAR  = 2'h2;
    localparam logic [1:0] TCO_OM_SET    = 2'h3;

    typedef enum logic [2:0] {
        TCO_WC_NORMAL = 3'b000,
        TCO_WC_CTC    = 3'b001,
        TCO_WC_FAST   = 3'b010,
        TCO_WC_PHASE  = 3'b011,
        TCO_WC_PFC    = 3'b100,
        TCO_WC_RSVD   = 3'b101
    } tco_wclass_type;

    // Waveform select decode into class
    function automatic tco_wclass_type tco_decode(input logic [3:0] sel);
        tco_wclass_type c;
        c = TCO_WC_NORMAL;
        case (sel)
            4'h0: c = TCO_WC_NORMAL;
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb: c = TCO_WC_PHASE;
            4'h4, 4'hc: c = TCO_WC_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: c = TCO_WC_FAST;
            4'h8, 4'h9: c = TCO_WC_PFC;
            default: c = TCO_WC_RSVD;
        endcase
        return c;
    endfunction
endpackage

// ===== design/tco_chan.sv
// One compare-output waveform channel
`timescale 1ns/1ps
module tco_chan (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    arst_n,
    // Configuration
    input  wire logic [1:0]              chan_out_mode,
    input  wire tco_pkg::tco_wclass_type wclass,
    input  wire logic                    waveform_sel_top_bit,
    input  wire logic                    toggle_allowed,
    // Timer events
    input  wire logic                    match,
    input  wire logic                    at_top,
    input  wire logic                    match_is_top,
    input  wire logic                    count_down,
    input  wire logic                    force_match,
    // Output
    output logic                         wave_out,
    output logic                         pin_override
);
    import tco_pkg::*;

    logic wave_reg;
    logic wave_next;
    logic is_pwm;
    logic is_plain;

    // ----------------------------------------
    // Pin takeover
    // ----------------------------------------
    // mode field nonzero takes the pin
    assign pin_override = (chan_out_mode != TCO_OM_OFF);
    assign wave_out     = wave_reg;
    assign is_pwm       = (wclass == TCO_WC_FAST) || (wclass == TCO_WC_PHASE) || (wclass == TCO_WC_PFC);
    // Reserved select is in neither group, so the output simply holds there
    assign is_plain     = (wclass == TCO_WC_NORMAL) || (wclass == TCO_WC_CTC);

    // Next output level per class and mode
    always_comb begin
        wave_next = wave_reg;
        if (is_plain) begin
            if (match || force_match) begin
                case (chan_out_mode)
                    TCO_OM_TOGGLE: wave_next = ~wave_reg;
                    TCO_OM_CLEAR:  wave_next = 1'b0;
                    TCO_OM_SET:    wave_next = 1'b1;
                    default:       wave_next = wave_reg;
                endcase
            end
        end else if (is_pwm && chan_out_mode == TCO_OM_TOGGLE) begin
            // toggle only on channel A with top bit set
            if (match && waveform_sel_top_bit && toggle_allowed) begin
                wave_next = ~wave_reg;
            end
        end else if (is_pwm && chan_out_mode[1]) begin
            if (wclass == TCO_WC_FAST) begin
                // fast PWM set or clear at TOP and match
                // match equal to TOP ignored, TOP action wins
                if (at_top) begin
                    wave_next = ~chan_out_mode[0];
                end else if (match && !match_is_top) begin
                    wave_next = chan_out_mode[0];
                end
            end else if (match) begin
                wave_next = count_down ? ~chan_out_mode[0] : chan_out_mode[0];
            end
        end
    end

    // Output level register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wave_reg <= 1'b0;
        end else begin
            wave_reg <= wave_next;
        end
    end

    // clear mode drives low after a match
    non_pwm_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (is_plain && match && chan_out_mode == TCO_OM_CLEAR) |=> !wave_out)
        else $error("clear on match failed");
    // toggle mode inverts on a match
    non_pwm_toggle_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (is_plain && match && chan_out_mode == TCO_OM_TOGGLE) |=> wave_out != $past(wave_out))
        else $error("toggle on match failed");
    // fast PWM mode 10 sets at TOP
    fast_top_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (wclass == TCO_WC_FAST && at_top && chan_out_mode == TCO_OM_CLEAR) |=> wave_out)
        else $error("fast PWM TOP set failed");
    fast_top_ign_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (wclass == TCO_WC_FAST && match && match_is_top && !at_top && chan_out_mode[1])
        |=> wave_out == $past(wave_out))
        else $error("match at TOP not ignored");
    phase_down_a: assert property (@(posedge mclk) disable iff (!arst_n)
        ((wclass == TCO_WC_PHASE || wclass == TCO_WC_PFC) && match && count_down
         && chan_out_mode == TCO_OM_SET) |=> !wave_out)
        else $error("down-count match action wrong");
    // mode 01 in PWM without top bit holds
    pwm_off_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (is_pwm && chan_out_mode == TCO_OM_TOGGLE && !waveform_sel_top_bit) |=> $stable(wave_out))
        else $error("PWM mode 01 changed output");
    // reserved select leaves the output alone
    rsvd_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (wclass == TCO_WC_RSVD) |=> $stable(wave_out))
        else $error("reserved select changed output");
endmodule

// ===== test/tco_cpu_model.sv
// CPU-side model: drives the I/O bus and the 16-bit access strobes
`timescale 1ns/1ps
module tco_cpu_model (
    // Clock
    input  wire logic       mclk,
    // I/O bus
    output logic      [7:0] io_addr,
    output logic      [7:0] io_wdata,
    output logic            io_wr,
    output logic            io_rd,
    // 16-bit access strobes
    output logic            wide_lo_wr,
    output logic            wide_hi_wr,
    output logic            wide_lo_rd
);
    // Idle bus at time zero
    initial begin
        {io_addr, io_wdata, io_wr, io_rd, wide_lo_wr, wide_hi_wr, wide_lo_rd} = '0;
    end

    // One-cycle strobe, then one free cycle; data not held past the strobe
    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic [4:0] s);
        @(posedge mclk);
        io_addr  <= a;
        io_wdata <= d;
        {io_wr, io_rd, wide_lo_wr, wide_hi_wr, wide_lo_rd} <= s;
        @(posedge mclk);
        {io_wr, io_rd, wide_lo_wr, wide_hi_wr, wide_lo_rd} <= '0;
        io_wdata <= ~d;
    endtask

    // pair issued with one quiet cycle between high and low byte
    // upper byte load may be skipped when shared
    task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic with_hi);
        if (with_hi) bus(8'h00, hi, 5'b00010);
        bus(8'h00, lo, 5'b00100);
    endtask
endmodule

// ===== test/tco_top_tb.sv
// Self-checking testbench for the compare-output control block
`timescale 1ns/1ps
module tco_top_tb;
    logic mclk, arst_n, match_a, match_b, match_a_is_top, match_b_is_top, at_top, count_down, force_a, force_b;
    logic [7:0] io_addr, io_wdata, io_rdata, wide_hi_src, wide_temp, d;
    logic io_wr, io_rd, wide_lo_wr, wide_hi_wr, wide_lo_rd, wide_load, rd_d;
    logic wave_out_a, wave_out_b, pin_override_a, pin_override_b;
    logic [1:0] waveform_sel_high, w;
    logic [15:0] wide_wdata;
    logic [15:0] rq[$];
    logic [15:0] wq[$];
    int bad_count = 0, comparisons = 0, seed = 7, c;
    logic pin_dir_a, pin_a;
    // Pin model: port level shows inverted unless the waveform owns the pin
    assign pin_a = (pin_dir_a && pin_override_a) ? wave_out_a : ~wave_out_a;

    tco_top DUT (.mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .io_rdata(io_rdata), .wide_lo_wr(wide_lo_wr), .wide_hi_wr(wide_hi_wr),
        .wide_lo_rd(wide_lo_rd), .wide_hi_src(wide_hi_src), .wide_temp(wide_temp), .wide_wdata(wide_wdata),
        .wide_load(wide_load), .waveform_sel_high(waveform_sel_high), .match_a(match_a), .match_b(match_b),
        .match_a_is_top(match_a_is_top), .match_b_is_top(match_b_is_top), .at_top(at_top),
        .count_down(count_down), .force_a(force_a), .force_b(force_b), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .pin_override_a(pin_override_a), .pin_override_b(pin_override_b));
    tco_cpu_model cpu (.mclk(mclk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .wide_lo_wr(wide_lo_wr), .wide_hi_wr(wide_hi_wr), .wide_lo_rd(wide_lo_rd));

    // ----------------------------------------
    // Clock, report and helpers
    // ----------------------------------------
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Control register write and queued read
    task automatic wc(input logic [7:0] v);
        cpu.bus(8'h2f, v, 5'b10000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back({8'h00, e});
        cpu.bus(a, 8'h00, 5'b01000);
    endtask

    // Event pulse {match_a, match_b, at_top, force_a, force_b}, then both waves checked
    task automatic ev(input logic [4:0] e, input logic [1:0] ew);
        @(posedge mclk);
        {match_a, match_b, at_top, force_a, force_b} <= e;
        @(posedge mclk);
        {match_a, match_b, at_top, force_a, force_b} <= '0;
        @(negedge mclk);
        chk("wave_out", {14'h0, ew}, {14'h0, wave_out_a, wave_out_b});
        chk("pin_a", {15'h0, ew[1]}, {15'h0, pin_a});
    endtask

    // Own decode: 0 non-PWM, 1 fast, 2 dual-slope, 3 reserved
    function automatic int cls(input int k);
        case (k)
            0, 4, 12: return 0;
            5, 6, 7, 14, 15: return 1;
            13: return 3;
            default: return 2;
        endcase
    endfunction

    // Result watcher: pops the oldest note when a result shows
    always @(posedge mclk) begin
        if (rd_d === 1'b1) chk("io_rdata", rq.pop_front(), {8'h00, io_rdata});
        if (wide_load === 1'b1) chk("wide_wdata", wq.pop_front(), wide_wdata);
        rd_d <= io_rd;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n = 0;
        // software sets the pin direction to output
        pin_dir_a = 1'b1;
        {match_a, match_b, match_a_is_top, match_b_is_top, at_top, count_down, force_a, force_b} = '0;
        waveform_sel_high = 2'b00;
        wide_hi_src = 8'h00;
        repeat (4) @(posedge mclk);
        arst_n <= 1;
        rd(8'h2f, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            wc(d);
            rd(8'h2f, d & 8'hf3);
            chk("pin_override", {14'h0, |d[7:6], |d[5:4]}, {14'h0, pin_override_a, pin_override_b});
        end
        cpu.bus(8'h2e, 8'h5a, 5'b10000);
        rd(8'h2e, 8'h00);
        rd(8'h2f, d & 8'hf3);
        // 16-bit path: shared upper byte, reuse, low-read latch
        wide_hi_src <= 8'hab;
        wq.push_back(16'h01ff);
        cpu.wr16(8'h01, 8'hff, 1'b1);
        wq.push_back(16'h0134);
        cpu.wr16(8'h77, 8'h34, 1'b0);
        cpu.bus(8'h00, 8'h00, 5'b00001);
        @(negedge mclk);
        chk("wide_temp", 16'h00ab, {8'h00, wide_temp});
        wq.push_back(16'hab55);
        cpu.wr16(8'h00, 8'h55, 1'b0);
        // Sweep every select code: A in clear mode, B in set mode; a dual-slope down-count match sets A and clears B
        w = 2'b00;
        count_down <= 1;
        for (int i = 0; i < 16; i++) begin
            c = cls(i);
            waveform_sel_high <= 2'(i >> 2);
            wc({6'b101100, 2'(i)});
            if (c == 0 || c == 1) w = 2'b01;
            if (c == 2) w = 2'b10;
            ev(5'b11000, w);
            if (c == 1) w = 2'b10;
            ev(5'b00100, w);
        end
        // Non-PWM toggle on match and on force
        waveform_sel_high <= 2'b00;
        wc(8'h50);
        w = w ^ 2'b11;
        ev(5'b11000, w);
        w = w ^ 2'b10;
        ev(5'b00010, w);
        // Dual-slope toggle code: holds with top bit clear, A only with it set
        wc(8'h51);
        ev(5'b11000, w);
        ev(5'b00011, w);
        waveform_sel_high <= 2'b10;
        wc(8'h51);
        w = w ^ 2'b10;
        ev(5'b11000, w);
        // Fast PWM, compare equal to TOP
        waveform_sel_high <= 2'b01;
        wc(8'h81);
        ev(5'b00100, {1'b1, w[0]});
        match_a_is_top <= 1;
        ev(5'b10000, {1'b1, w[0]});
        match_a_is_top <= 0;
        ev(5'b10000, {1'b0, w[0]});
        repeat (4) @(posedge mclk);
        if (rq.size() != 0 || wq.size() != 0) bad_count++;
        finish_test();
    end
endmodule
